// [design/pic_defs.svh]
// Constants for the priority interrupt controller: offsets, fields, resets, vectors
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

`define PIC_OPT_ADDR 8'hC8
`define PIC_STAT_ADDR 8'hD0
`define PIC_FLAG_ADDR 8'hD4
`define PIC_ADDR_MASK 8'hFC

`define PIC_LES_BIT 6
`define PIC_ESB_BIT 5
`define PIC_GEN_BIT 4
`define PIC_OPT_RST 3'h0

`define PIC_VEC_S0 12'hFFC
`define PIC_VEC_S1 12'hFF6
`define PIC_VEC_S2 12'hFF4
`define PIC_VEC_S3 12'hFF2
`define PIC_VEC_S4 12'hFF0

`define PIC_PIN_IDLE 3'h7

`endif

// [design/pic_edge_latch.sv]
// Edge detector with a single request latch, first edge kept
module pic_edge_latch (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Line and control
    input wire logic lvl_i,
    input wire logic rise_i,
    input wire logic arm_i,
    input wire logic clr_i,
    // Request
    output logic req_o
);
    import pic_pkg::*;

    typedef struct packed {
        logic prev;
        logic req;
    } pic_lat_s;

    pic_lat_s r, r_nxt;
    logic edge_seen;

    always_comb begin
        edge_seen = rise_i ? (lvl_i & ~r.prev) : (~lvl_i & r.prev);
        r_nxt = r;
        r_nxt.prev = lvl_i;
        // Set wins over clear; later edges fold into a set latch
        r_nxt.req = (edge_seen & arm_i) | (r.req & ~clr_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '{prev: 1'b1, req: 1'b0};
        end else begin
            r <= r_nxt;
        end
    end

    assign req_o = r.req;
endmodule

// [design/pic_flag_bank.sv]
// Three carry/zero flag pairs, one per operating mode
module pic_flag_bank (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pair select and write
    input wire pic_pkg::pic_mode_e sel_i,
    input wire logic we_i,
    input wire logic carry_i,
    input wire logic zero_i,
    // Pairs, {nmi, irq, normal}, carry above zero
    output logic [5:0] pairs_o
);
    import pic_pkg::*;

    typedef struct packed {
        logic [5:0] pairs;
    } pic_fb_s;

    pic_fb_s r, r_nxt;

    always_comb begin
        r_nxt = r;
        for (int i = 0; i < 3; i++) begin
            if (we_i && sel_i[i]) begin
                r_nxt.pairs[2*i +: 2] = {carry_i, zero_i};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign pairs_o = r.pairs;
endmodule

// [design/pic_pkg.sv]
// Types shared by the priority interrupt controller modules
package pic_pkg;

    typedef enum logic [2:0] {
        PIC_MODE_NORM = 3'b001,
        PIC_MODE_IRQ = 3'b010,
        PIC_MODE_NMI = 3'b100
    } pic_mode_e;

    typedef enum logic [4:0] {
        PIC_ST_IDLE = 5'b00001,
        PIC_ST_SWAP = 5'b00010,
        PIC_ST_PUSH = 5'b00100,
        PIC_ST_CLR = 5'b01000,
        PIC_ST_LOAD = 5'b10000
    } pic_step_e;

    typedef struct packed {
        logic src1_level_select;
        logic src2_polarity_select;
        logic global_irq_enable;
    } pic_opt_s;

    typedef struct packed {
        logic inst_end;
        logic return_from_handler_op;
        logic sleep;
        logic ldi_clr;
        logic flag_we;
        logic carry;
        logic zero;
    } pic_core_in_s;

    typedef struct packed {
        logic take;
        logic push_pc;
        logic pop_pc;
        logic flag_swap;
        logic wake;
        logic carry;
        logic zero;
        pic_mode_e mode;
        logic [11:0] vector;
    } pic_core_out_s;

endpackage

// [design/pic_top.sv]
// Priority interrupt controller: sources, option register, entry/return sequencing
// Contract
// - Four maskable sources plus top-priority non-maskable
// - Fixed vector address per source
// - Accepted request loads its vector into PC
// - ORed events stay readable per source
// - Non-maskable preempts; maskable never nests
// - Maskable order fixed, source 1 first
// - Global enable gates all maskable sources
// - Global enable off blocks every wake-up
// - Non-maskable latch cleared at routine start
// - Source 1 level or falling edge
// - Source 2 edge, polarity selectable
// - Sources 3 and 4 level only
// - Edge latch holds until routine starts
// - Only first edge kept while busy
// - Lines sampled at each instruction end
// - Three flag pairs switched automatically
// - Swap, push, inhibit, clear, load in order
// - Return restores flags and pops PC
// - Clear-load defect keeps normal flags
// - Option register write-only, resets to zero
// - Option bits six, five, four used
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`include "pic_defs.svh"

module pic_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Request pins, active low except source 2 when its polarity bit selects rising edges
    input wire logic nmi_pin_i,
    input wire logic src1_pin_i,
    input wire logic src2_pin_i,
    // Peripheral events, active high
    input wire logic [2:0] src3_evt_i,
    input wire logic [1:0] src4_evt_i,
    // Processor core
    input wire pic_pkg::pic_core_in_s core_i,
    output pic_pkg::pic_core_out_s core_o
);
    import pic_pkg::*;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        pic_opt_s opt;
        pic_mode_e mode;
        pic_mode_e fsel;
        pic_mode_e nmi_prev;
        pic_mode_e nmi_prev_fsel;
        pic_step_e step;
        logic [2:0] src;
        logic [2:0] ev3;
        logic [1:0] ev4;
        logic ack;
        logic [31:0] rdat;
        pic_core_out_s cout;
    } pic_top_s;

    localparam pic_top_s PIC_RST = '{
        s1: `PIC_PIN_IDLE,
        s2: `PIC_PIN_IDLE,
        opt: `PIC_OPT_RST,
        mode: PIC_MODE_NORM,
        fsel: PIC_MODE_NORM,
        nmi_prev: PIC_MODE_NORM,
        nmi_prev_fsel: PIC_MODE_NORM,
        step: PIC_ST_IDLE,
        src: 3'h0,
        ev3: 3'h0,
        ev4: 2'h0,
        ack: 1'b0,
        rdat: 32'h0,
        cout: '{
            take: 1'b0,
            push_pc: 1'b0,
            pop_pc: 1'b0,
            flag_swap: 1'b0,
            wake: 1'b0,
            carry: 1'b0,
            zero: 1'b0,
            mode: PIC_MODE_NORM,
            vector: 12'h000
        }
    };

    pic_top_s r, r_nxt;

    logic [2:0] lat;
    logic [2:0] rise_v;
    logic [2:0] arm_v;
    logic [2:0] clr_v;
    logic [3:0] mreq;
    logic [5:0] pairs;
    logic hit;
    logic boundary;
    logic awake_ok;

    // Highest maskable source pending, 1 first and 4 last
    function automatic logic [2:0] first_src(input logic [3:0] req);
        logic [2:0] s;
        s = 3'h0;
        for (int i = 3; i >= 0; i--) begin
            if (req[i]) begin
                s = 3'(i + 1);
            end
        end
        return s;
    endfunction

    // Vector start address for a source
    function automatic logic [11:0] vec_of(input logic [2:0] s);
        logic [11:0] v;
        unique case (s)
            3'h0: v = `PIC_VEC_S0;
            3'h1: v = `PIC_VEC_S1;
            3'h2: v = `PIC_VEC_S2;
            3'h3: v = `PIC_VEC_S3;
            default: v = `PIC_VEC_S4;
        endcase
        return v;
    endfunction

    // Carry/zero of the pair chosen by a mode
    function automatic logic [1:0] pair_of(input pic_mode_e m, input logic [5:0] p);
        logic [1:0] f;
        f = p[1:0];
        if (m[1]) begin
            f = p[3:2];
        end
        if (m[2]) begin
            f = p[5:4];
        end
        return f;
    endfunction

    // Register decode of a bus address, low two bits ignored
    function automatic logic [1:0] reg_of(input logic [7:0] a);
        logic [1:0] k;
        k = 2'h0;
        if ((a & `PIC_ADDR_MASK) == `PIC_OPT_ADDR) begin
            k = 2'h1;
        end
        if ((a & `PIC_ADDR_MASK) == `PIC_STAT_ADDR) begin
            k = 2'h2;
        end
        if ((a & `PIC_ADDR_MASK) == `PIC_FLAG_ADDR) begin
            k = 2'h3;
        end
        return k;
    endfunction

    // Routine mode that a source enters
    function automatic pic_mode_e mode_of(input logic [2:0] s);
        pic_mode_e m;
        m = PIC_MODE_IRQ;
        if (s == 3'h0) begin
            m = PIC_MODE_NMI;
        end
        return m;
    endfunction

    // Status word: pins, events, sources 4 and 3 pending, latches, mode
    function automatic logic [31:0] stat_word(input pic_top_s s, input logic [3:0] m, input logic [2:0] l);
        logic [31:0] w;
        w = {
            16'h0,
            s.s2,
            s.ev4,
            s.ev3,
            m[3],
            m[2],
            l,
            s.mode
        };
        return w;
    endfunction

    // Line 0 falling, line 1 falling unless level, line 2 by polarity
    assign rise_v = {r.opt.src2_polarity_select, 2'b00};
    assign arm_v = {1'b1, ~r.opt.src1_level_select, 1'b1};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_lat
            assign clr_v[gi] = (r.step == PIC_ST_CLR) && (r.src == 3'(gi));
            pic_edge_latch u_lat (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .lvl_i(r.s2[gi]),
                .rise_i(rise_v[gi]),
                .arm_i(arm_v[gi]),
                .clr_i(clr_v[gi]),
                .req_o(lat[gi])
            );
        end
    endgenerate

    pic_flag_bank u_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(r.fsel),
        .we_i(core_i.flag_we),
        .carry_i(core_i.carry),
        .zero_i(core_i.zero),
        .pairs_o(pairs)
    );

    // Maskable requests, ORed events; level lines keep no memory
    assign mreq = {
        |src4_evt_i,
        |src3_evt_i,
        lat[2],
        r.opt.src1_level_select ? ~r.s2[1] : lat[1]
    };

    assign hit = wb_cyc_i & wb_stb_i & ~r.ack;
    assign boundary = core_i.inst_end | core_i.sleep;
    assign awake_ok = ~core_i.sleep | r.opt.global_irq_enable;

    always_comb begin
        r_nxt = r;
        r_nxt.s1 = {src2_pin_i, src1_pin_i, nmi_pin_i};
        r_nxt.s2 = r.s1;
        r_nxt.ev3 = src3_evt_i;
        r_nxt.ev4 = src4_evt_i;
        r_nxt.cout.take = 1'b0;
        r_nxt.cout.push_pc = 1'b0;
        r_nxt.cout.pop_pc = 1'b0;
        r_nxt.cout.flag_swap = 1'b0;

        // Bus slave, one wait state, unmapped reads zero
        r_nxt.ack = hit;
        if (hit) begin
            r_nxt.rdat = 32'h0;
            if (wb_we_i) begin
                if ((reg_of(wb_adr_i) == 2'h1) && wb_sel_i[0]) begin
                    r_nxt.opt.src1_level_select = wb_dat_i[`PIC_LES_BIT];
                    r_nxt.opt.src2_polarity_select = wb_dat_i[`PIC_ESB_BIT];
                    r_nxt.opt.global_irq_enable = wb_dat_i[`PIC_GEN_BIT];
                end
            end else begin
                unique case (reg_of(wb_adr_i))
                    2'h2: r_nxt.rdat = stat_word(r, mreq, lat);
                    2'h3: r_nxt.rdat = {26'h0, pairs};
                    default: r_nxt.rdat = 32'h0;
                endcase
            end
        end

        // Wake only while global enable is set, even for non-maskable
        r_nxt.cout.wake = core_i.sleep & r.opt.global_irq_enable & (lat[0] | (|mreq));

        unique case (r.step)
            PIC_ST_IDLE: begin
                if (core_i.return_from_handler_op && r.mode != PIC_MODE_NORM) begin
                    r_nxt.cout.pop_pc = 1'b1;
                    if (r.mode == PIC_MODE_NMI) begin
                        r_nxt.mode = r.nmi_prev;
                        r_nxt.fsel = r.nmi_prev_fsel;
                    end else begin
                        r_nxt.mode = PIC_MODE_NORM;
                        r_nxt.fsel = PIC_MODE_NORM;
                    end
                end else if (boundary && awake_ok) begin
                    if (lat[0] && r.mode != PIC_MODE_NMI) begin
                        r_nxt.src = 3'h0;
                        r_nxt.step = PIC_ST_SWAP;
                    end else if (r.opt.global_irq_enable && r.mode == PIC_MODE_NORM && (|mreq)) begin
                        r_nxt.src = first_src(mreq);
                        r_nxt.step = PIC_ST_SWAP;
                    end
                end
            end
            PIC_ST_SWAP: begin
                r_nxt.cout.flag_swap = 1'b1;
                if (mode_of(r.src) == PIC_MODE_NMI) begin
                    r_nxt.nmi_prev = r.mode;
                    r_nxt.nmi_prev_fsel = r.fsel;
                    r_nxt.fsel = PIC_MODE_NMI;
                end else if (!core_i.ldi_clr) begin
                    r_nxt.fsel = PIC_MODE_IRQ;
                end
                r_nxt.step = PIC_ST_PUSH;
            end
            PIC_ST_PUSH: begin
                r_nxt.cout.push_pc = 1'b1;
                r_nxt.step = PIC_ST_CLR;
            end
            PIC_ST_CLR: begin
                // Inhibit maskable lines, non-maskable stays live unless entering the non-maskable routine
                r_nxt.mode = mode_of(r.src);
                r_nxt.step = PIC_ST_LOAD;
            end
            PIC_ST_LOAD: begin
                r_nxt.cout.take = 1'b1;
                r_nxt.cout.vector = vec_of(r.src);
                r_nxt.step = PIC_ST_IDLE;
            end
            default: begin
                r_nxt.step = PIC_ST_IDLE;
            end
        endcase

        r_nxt.cout.mode = r_nxt.mode;
        {r_nxt.cout.carry, r_nxt.cout.zero} = pair_of(r_nxt.fsel, pairs);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= PIC_RST;
        end else begin
            r <= r_nxt;
        end
    end

    assign wb_dat_o = r.rdat;
    assign wb_ack_o = r.ack;
    assign core_o = r.cout;
endmodule

// [dv/pic_checker.sv]
// Port assertions for the priority interrupt controller
`include "pic_defs.svh"
module pic_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and events
    input wire logic nmi_pin_i,
    input wire logic src1_pin_i,
    input wire logic src2_pin_i,
    input wire logic [2:0] src3_evt_i,
    input wire logic [1:0] src4_evt_i,
    // Core
    input wire pic_pkg::pic_core_in_s core_i,
    input wire pic_pkg::pic_core_out_s core_o
);
    import pic_pkg::*;
    logic gen_r;
    logic [3:0] gen_low_r;
    // Tracks the enable bit and how long it has been off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_r <= 1'b0;
            gen_low_r <= 4'h0;
        end else begin
            if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                && (wb_adr_i & `PIC_ADDR_MASK) == `PIC_OPT_ADDR) begin
                gen_r <= wb_dat_i[`PIC_GEN_BIT];
            end
            gen_low_r <= gen_r ? 4'h0 : ((gen_low_r == 4'hF) ? 4'hF : gen_low_r + 4'h1);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence entry_tail_s;
        core_o.push_pc ##2 core_o.take;
    endsequence
    wb_ack_a: assert property (wb_req_s |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not a single pulse");
    opt_read_a: assert property (wb_req_s ##0 (!wb_we_i && (wb_adr_i & `PIC_ADDR_MASK) == `PIC_OPT_ADDR)
        |=> wb_dat_o == 32'h0)
        else $error("option register read not zero");
    entry_order_a: assert property (core_o.flag_swap |=> entry_tail_s)
        else $error("entry steps out of order");
    mode_switch_a: assert property (core_o.push_pc |=> !$stable(core_o.mode))
        else $error("mode not switched after push");
    vec_legal_a: assert property (core_o.take |-> core_o.vector inside {`PIC_VEC_S0, `PIC_VEC_S1,
        `PIC_VEC_S2, `PIC_VEC_S3, `PIC_VEC_S4})
        else $error("illegal vector");
    no_nest_a: assert property (core_o.take && $past(core_o.mode, 5) != PIC_MODE_NORM
        |-> core_o.vector == `PIC_VEC_S0)
        else $error("maskable routine preempted");
    ret_pop_a: assert property (core_i.return_from_handler_op && core_o.mode != PIC_MODE_NORM |=> core_o.pop_pc)
        else $error("return without pop");
    mask_gen_a: assert property (gen_low_r >= 4'h7 && core_o.take |-> core_o.vector == `PIC_VEC_S0)
        else $error("maskable taken while disabled");
    wake_block_a: assert property (gen_low_r >= 4'h3 |-> !core_o.wake)
        else $error("wake while disabled");
    wake_sleep_a: assert property (core_o.wake |-> $past(core_i.sleep))
        else $error("wake outside sleep");
endmodule

// [dv/pic_core_model.sv]
// Processor core model: instruction boundaries and timed returns
module pic_core_model #(
    parameter int DWELL = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic take_i,
    input wire logic sleep_i,
    output pic_pkg::pic_core_in_s core_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import pic_pkg::*;
    logic [1:0] phase_r;
    logic [1:0] depth_r;
    logic [5:0] dwell_r;
    // Boundary every four cycles; each routine returns after a dwell
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_r <= 2'h0;
            depth_r <= 2'h0;
            dwell_r <= 6'h0;
            core_o <= '0;
        end else begin
            phase_r <= phase_r + 2'h1;
            core_o <= '0;
            core_o.sleep <= sleep_i;
            core_o.inst_end <= (phase_r == 2'h3) && !sleep_i;
            core_o.flag_we <= take_i;
            core_o.carry <= take_i;
            core_o.zero <= take_i;
            if (take_i) begin
                depth_r <= depth_r + 2'h1;
                dwell_r <= 6'(DWELL);
            end else if (dwell_r != 6'h0) begin
                dwell_r <= dwell_r - 6'h1;
            end else if (depth_r != 2'h0) begin
                core_o.return_from_handler_op <= 1'b1;
                depth_r <= depth_r - 2'h1;
                dwell_r <= 6'(DWELL);
            end
        end
    end
endmodule

// [dv/test_priority_interrupt_controller.sv]
// Self-checking bench for the priority interrupt controller
`include "pic_defs.svh"
module test_priority_interrupt_controller;
    timeunit 1ns;
    timeprecision 1ns;
    import pic_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc, wb_stb, wb_we, wb_ack, nmi_pin, src1_pin, src2_pin, sleep;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat, rd;
    logic [2:0] src3_evt;
    logic [1:0] src4_evt;
    pic_core_in_s core_in;
    pic_core_out_s core_out;
    int err_count = 0;
    int n_compared = 0;
    int t;
    always #5 clk_i = ~clk_i;
    pic_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .nmi_pin_i(nmi_pin), .src1_pin_i(src1_pin), .src2_pin_i(src2_pin), .src3_evt_i(src3_evt),
        .src4_evt_i(src4_evt), .core_i(core_in), .core_o(core_out));
    pic_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .take_i(core_out.take), .sleep_i(sleep),
        .core_o(core_in));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task print_verdict();
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'hF;
        wb_wdat <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        check(wb_ack, 1'b1);
    endtask
    task wait_take(input logic [11:0] vec);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (core_out.take !== 1'b1 && n < 300);
        check(core_out.take, 1'b1);
        check(core_out.vector, vec);
    endtask
    task no_take(input int c);
        t = 0;
        repeat (c) begin
            @(posedge clk_i);
            if (core_out.take === 1'b1) t++;
        end
    endtask
    task t_reset();
        wb(1'b0, `PIC_OPT_ADDR, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, `PIC_OPT_ADDR, 32'hFF);
        wb(1'b0, `PIC_OPT_ADDR, 32'h0);
        check(rd, 32'h0);
    endtask
    task t_priority();
        wb(1'b1, `PIC_OPT_ADDR, 32'h40);
        src1_pin <= 1'b0;
        src3_evt <= 3'h4;
        src4_evt <= 2'h1;
        wb(1'b0, `PIC_STAT_ADDR, 32'h0);
        check(rd[12:8], 5'h0C);
        wb(1'b1, `PIC_OPT_ADDR, 32'h50);
        wait_take(`PIC_VEC_S1);
        src1_pin <= 1'b1;
        wait_take(`PIC_VEC_S3);
        src3_evt <= 3'h0;
        wait_take(`PIC_VEC_S4);
        src4_evt <= 2'h0;
        wb(1'b0, `PIC_FLAG_ADDR, 32'h0);
        check(rd[5:0], 6'h0C);
    endtask
    task t_nmi();
        wb(1'b1, `PIC_OPT_ADDR, 32'h10);
        src4_evt <= 2'h2;
        wait_take(`PIC_VEC_S4);
        src4_evt <= 2'h0;
        nmi_pin <= 1'b0;
        wait_take(`PIC_VEC_S0);
        nmi_pin <= 1'b1;
        no_take(80);
        check(t, 0);
        check(core_out.mode, PIC_MODE_NORM);
        check({core_out.carry, core_out.zero}, 2'b00);
        wb(1'b0, `PIC_FLAG_ADDR, 32'h0);
        check(rd[5:0], 6'h3C);
    endtask
    task t_edges();
        src1_pin <= 1'b0;
        wait_take(`PIC_VEC_S1);
        src1_pin <= 1'b1;
        src2_pin <= 1'b0;
        wait_take(`PIC_VEC_S2);
        src2_pin <= 1'b1;
        no_take(60);
        check(t, 0);
        wb(1'b1, `PIC_OPT_ADDR, 32'h20);
        repeat (2) begin
            src2_pin <= 1'b0;
            repeat (4) @(posedge clk_i);
            src2_pin <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
        wb(1'b1, `PIC_OPT_ADDR, 32'h30);
        wait_take(`PIC_VEC_S2);
        no_take(60);
        check(t, 0);
    endtask
    task t_gen_off();
        wb(1'b1, `PIC_OPT_ADDR, 32'h0);
        src3_evt <= 3'h1;
        no_take(40);
        check(t, 0);
        nmi_pin <= 1'b0;
        wait_take(`PIC_VEC_S0);
        nmi_pin <= 1'b1;
        no_take(40);
        sleep <= 1'b1;
        no_take(20);
        check(core_out.wake, 1'b0);
        wb(1'b1, `PIC_OPT_ADDR, 32'h10);
        repeat (2) @(posedge clk_i);
        check(core_out.wake, 1'b1);
        wait_take(`PIC_VEC_S3);
        sleep <= 1'b0;
        src3_evt <= 3'h0;
        no_take(60);
        check(core_out.mode, PIC_MODE_NORM);
    endtask
    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat, sleep, src3_evt, src4_evt} = '0;
        {nmi_pin, src1_pin, src2_pin} = 3'h7;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_reset();
        t_priority();
        t_nmi();
        t_edges();
        t_gen_off();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end
endmodule
bind pic_top pic_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .nmi_pin_i(nmi_pin_i), .src1_pin_i(src1_pin_i), .src2_pin_i(src2_pin_i),
    .src3_evt_i(src3_evt_i), .src4_evt_i(src4_evt_i), .core_i(core_i), .core_o(core_o));
